// ---- irq_vectoring.sv ----
`timescale 1ns/10ps
module irq_vectoring
  import irq_vec_pkg::*;
(
  input  logic       mclk,
  input  logic       reset,
  input  logic [2:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_wr,
  input  logic       reg_rd,
  output logic [7:0] reg_rdata,
  input  logic       counter0_overflow,
  input  logic       counter1_overflow,
  input  logic       serial_byte_done,
  input  logic       conv_done,
  input  logic       periph_edge,
  input  logic       eeprom_done,
  input  logic       low_volt_event,
  input  logic       cmp_out,
  input  logic       tick_source_clock,
  input  logic       stack_full,
  output logic       call_pulse,
  output logic [7:0] call_vector,
  output logic       wake_up
);

  logic [CORE_EN_W-1:0]   core_en;
  logic [CORE_FLAG_W-1:0] core_flag;
  logic [N_MEMBERS-1:0]   member_en;
  logic [N_MEMBERS-1:0]   member_flag;
  logic [7:0]             time_base_control;
  logic [SYS_DIV_W-1:0]   sys_div;
  logic [1:0]             sync1;
  logic [1:0]             sync2;
  logic [1:0]             sync3;
  logic [1:0]             level;
  logic [10:0]            all_prev;

  logic                   wr_ctrl;
  logic                   wr_flags;
  logic                   wr_men;
  logic                   wr_mflags;
  logic                   wr_tick;
  logic [1:0]             agree;
  logic                   cmp_change;
  logic                   tick_src_rise;
  logic                   sys_quarter;
  logic                   tick_step;
  logic                   tick0_pulse;
  logic                   tick1_pulse;
  logic [N_MEMBERS-1:0]   member_evt;
  logic                   shared_set;
  logic [CORE_FLAG_W-1:0] core_evt;
  logic [CORE_FLAG_W-1:0] pending;
  irq_src_t               take_src;
  logic                   take;
  logic [CORE_FLAG_W-1:0] svc_clear;
  logic [CORE_FLAG_W-1:0] next_core_flag;
  logic [N_MEMBERS-1:0]   next_member_flag;
  logic [CORE_EN_W-1:0]   next_core_en;
  logic [10:0]            all_flags;
  logic [7:0]             rd_mux;

  // Fixed priority: the lowest vector address wins.
  function automatic irq_src_t pick_src(input logic [CORE_FLAG_W-1:0] p);
    irq_src_t s;
    s = SRC_NONE;
    if (p[F_C0])
      s = SRC_C0;
    else if (p[F_C1])
      s = SRC_C1;
    else if (p[F_SER])
      s = SRC_SER;
    else if (p[F_SH])
      s = SRC_SH;
    return s;
  endfunction

  // Vector address and flag bit of a source.
  function automatic logic [7:0] vec_of(input irq_src_t s);
    logic [7:0] v;
    v = VEC_SHARED;
    if (s == SRC_C0)
      v = VEC_COUNTER0;
    else if (s == SRC_C1)
      v = VEC_COUNTER1;
    else if (s == SRC_SER)
      v = VEC_SERIAL;
    return v;
  endfunction

  function automatic logic [CORE_FLAG_W-1:0] bit_of(input irq_src_t s);
    logic [CORE_FLAG_W-1:0] b;
    b = '0;
    if (s == SRC_C0)
      b[F_C0] = 1'b1;
    else if (s == SRC_C1)
      b[F_C1] = 1'b1;
    else if (s == SRC_SER)
      b[F_SER] = 1'b1;
    else if (s == SRC_SH)
      b[F_SH] = 1'b1;
    return b;
  endfunction

  // Register write decode.
  assign wr_ctrl   = reg_wr && (reg_addr == ADDR_CORE_CTRL);
  assign wr_flags  = reg_wr && (reg_addr == ADDR_CORE_FLAGS);
  assign wr_men    = reg_wr && (reg_addr == ADDR_MEMBER_EN);
  assign wr_mflags = reg_wr && (reg_addr == ADDR_MEMBER_FLAGS);
  assign wr_tick   = reg_wr && (reg_addr == ADDR_TICK_CTRL);

  // The comparator and the time base clock are asynchronous, so
  // each passes three flops and counts once the last two agree.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          level[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= gi == 0 ? cmp_out : tick_source_clock;
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (agree[gi])
            level[gi] <= sync3[gi];
        end
      end
      assign agree[gi] = sync2[gi] == sync3[gi];
    end
  endgenerate

  assign cmp_change    = agree[0] && (sync3[0] != level[0]);
  assign tick_src_rise = agree[1] && sync3[1] && !level[1];

  // A quarter of the system clock is the other time base source.
  always_ff @(posedge mclk)
  begin
    if (reset)
      sys_div <= '0;
    else
      sys_div <= sys_div + SYS_DIV_W'(1);
  end

  assign sys_quarter = &sys_div;
  assign tick_step   = time_base_control[TICK_SEL_BIT] ? sys_quarter
                                                       : tick_src_rise;

  tick_divider u_tick (
    .mclk        (mclk),
    .reset       (reset),
    .run         (time_base_control[TICK_ON_BIT]),
    .step        (tick_step),
    .period_sel  (time_base_control[TICK0_SEL_LSB +: TICK0_SEL_W]),
    .tick0_pulse (tick0_pulse),
    .tick1_pulse (tick1_pulse)
  );

  // Member events and their contribution to the shared flag.
  assign member_evt = {low_volt_event, eeprom_done, periph_edge,
                       cmp_change, tick1_pulse, tick0_pulse,
                       conv_done};
  assign shared_set = |(member_evt & member_en);
  assign core_evt   = {shared_set, serial_byte_done,
                       counter1_overflow, counter0_overflow};

  // Requests that may be vectored, before the global gate.
  assign pending[F_C0]  = core_flag[F_C0] && core_en[C_EN0];
  assign pending[F_C1]  = core_flag[F_C1] && core_en[C_EN1];
  assign pending[F_SER] = core_flag[F_SER] && core_en[C_ENSER];
  assign pending[F_SH]  = core_flag[F_SH] && core_en[C_ENSH];
  assign take_src  = pick_src(pending);
  assign take      = core_en[C_GIE] && !stack_full
                     && (take_src != SRC_NONE);
  assign svc_clear = take ? bit_of(take_src) : '0;

  // Hardware sets win over both software and service clears.
  assign next_core_flag = ((wr_flags ? reg_wdata[CORE_FLAG_W-1:0]
                                     : core_flag) & ~svc_clear)
                          | core_evt;
  assign next_member_flag = (wr_mflags ? reg_wdata[N_MEMBERS-1:0]
                                       : member_flag) | member_evt;
  assign next_core_en = (wr_ctrl ? reg_wdata[CORE_EN_W-1:0] : core_en)
                        & ~(CORE_EN_W'(take) << C_GIE);

  // Flag and enable storage.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      core_en           <= CORE_EN_W'(REG_RESET);
      core_flag         <= CORE_FLAG_W'(REG_RESET);
      member_en         <= N_MEMBERS'(REG_RESET);
      member_flag       <= N_MEMBERS'(REG_RESET);
      time_base_control <= REG_RESET;
    end
    else
    begin
      core_en     <= next_core_en;
      core_flag   <= next_core_flag;
      member_flag <= next_member_flag;
      if (wr_men)
        member_en <= reg_wdata[N_MEMBERS-1:0];
      if (wr_tick)
        time_base_control <= reg_wdata;
    end
  end

  // The call is issued one cycle after the grant; the global enable
  // is already low by then, so a second call cannot follow at once.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      call_pulse  <= 1'b0;
      call_vector <= VEC_COUNTER0;
    end
    else
    begin
      call_pulse <= take;
      if (take)
        call_vector <= vec_of(take_src);
    end
  end

  // Wake-up ignores every enable bit.
  assign all_flags = {member_flag, core_flag};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      all_prev <= '0;
      wake_up  <= 1'b0;
    end
    else
    begin
      all_prev <= all_flags;
      wake_up  <= |(all_flags & ~all_prev);
    end
  end

  // Read mux; unmapped indices read as zero.
  assign rd_mux = (reg_addr == ADDR_CORE_CTRL)    ? 8'(core_en) :
                  (reg_addr == ADDR_CORE_FLAGS)   ? 8'(core_flag) :
                  (reg_addr == ADDR_MEMBER_EN)    ? 8'(member_en) :
                  (reg_addr == ADDR_MEMBER_FLAGS) ? 8'(member_flag) :
                  (reg_addr == ADDR_TICK_CTRL)    ? time_base_control :
                                                    REG_RESET;

  always_ff @(posedge mclk)
  begin
    if (reset)
      reg_rdata <= REG_RESET;
    else
      reg_rdata <= reg_rd ? rd_mux : REG_RESET;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_call_stack_free: assert property (
    call_pulse |-> $past(core_en[C_GIE]) && !$past(stack_full))
    else $error("Call issued without global enable or with full stack.");

  chk_counter0_vector: assert property (
    call_pulse && call_vector == VEC_COUNTER0
      |-> $past(core_flag[F_C0]) && $past(core_en[C_EN0]))
    else $error("Counter 0 vector without an enabled request.");

  chk_counter_flag_set: assert property (
    counter1_overflow |=> core_flag[F_C1] ##1 (core_flag[F_C1] || call_pulse
      || $past(wr_flags)))
    else $error("Counter 1 overflow did not set its flag.");

  chk_serial_service_clear: assert property (
    take && take_src == SRC_SER && !serial_byte_done
      |=> !core_flag[F_SER] && !core_en[C_GIE] && call_pulse
          && call_vector == VEC_SERIAL)
    else $error("Serial service did not clear flag and global enable.");

  chk_member_to_shared: assert property (
    (|(member_evt & member_en)) |=> core_flag[F_SH])
    else $error("Member request did not set the shared flag.");

  chk_member_flag_held: assert property (
    !wr_mflags |=> (member_flag & $past(member_flag)) == $past(member_flag))
    else $error("Member flag dropped without a software clear.");

  chk_priority_order: assert property (
    call_pulse && call_vector != VEC_COUNTER0 |-> !$past(pending[F_C0]))
    else $error("Lower vector request was passed over.");

  chk_wake_on_rise: assert property (
    $rose(core_flag[F_SER]) |=> wake_up)
    else $error("Flag rise gave no wake-up.");

  cov_serial_call: cover property (call_pulse && call_vector == VEC_SERIAL);
  cov_shared_call: cover property (call_pulse && call_vector == VEC_SHARED);
  cov_stack_hold: cover property (
    core_en[C_GIE] && pending != '0 && stack_full ##1 !stack_full
      ##1 call_pulse);
  cov_tick0_flag: cover property (tick0_pulse ##1 member_flag[M_TICK0]);

endmodule

// ---- irq_vec_pkg.sv ----
package irq_vec_pkg;

  // Register indices on the plain register port.
  localparam logic [2:0] ADDR_CORE_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_CORE_FLAGS   = 3'h1;
  localparam logic [2:0] ADDR_MEMBER_EN    = 3'h2;
  localparam logic [2:0] ADDR_MEMBER_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_TICK_CTRL    = 3'h4;

  // Core control bits.
  localparam int C_GIE   = 0;
  localparam int C_EN0   = 1;
  localparam int C_EN1   = 2;
  localparam int C_ENSER = 3;
  localparam int C_ENSH  = 4;
  localparam int CORE_EN_W = 5;

  // Core request flags.
  localparam int F_C0  = 0;
  localparam int F_C1  = 1;
  localparam int F_SER = 2;
  localparam int F_SH  = 3;
  localparam int CORE_FLAG_W = 4;

  // Member sources behind the shared interrupt.
  localparam int M_CONV   = 0;
  localparam int M_TICK0  = 1;
  localparam int M_TICK1  = 2;
  localparam int M_CMP    = 3;
  localparam int M_PERIPH = 4;
  localparam int M_EEPROM = 5;
  localparam int M_LVD    = 6;
  localparam int N_MEMBERS = 7;

  // Time base control fields.
  localparam int TICK_ON_BIT  = 7;
  localparam int TICK_SEL_BIT = 6;
  localparam int TICK0_SEL_LSB = 0;
  localparam int TICK0_SEL_W   = 3;
  localparam int TICK_CNT_W    = 15;
  localparam logic [15:0] TICK0_BASE_SPAN = 16'h0100;
  localparam logic [14:0] TICK1_MASK      = 15'h0fff;
  localparam int SYS_DIV_W = 2;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Call vectors.
  localparam logic [7:0] VEC_COUNTER0 = 8'h0c;
  localparam logic [7:0] VEC_COUNTER1 = 8'h10;
  localparam logic [7:0] VEC_SERIAL   = 8'h14;
  localparam logic [7:0] VEC_SHARED   = 8'h18;

  typedef enum {SRC_NONE, SRC_C0, SRC_C1, SRC_SER, SRC_SH} irq_src_t;

endpackage

// ---- tick_divider.sv ----
`timescale 1ns/10ps
module tick_divider
  import irq_vec_pkg::*;
(
  input  logic                   mclk,
  input  logic                   reset,
  input  logic                   run,
  input  logic                   step,
  input  logic [TICK0_SEL_W-1:0] period_sel,
  output logic                   tick0_pulse,
  output logic                   tick1_pulse
);

  logic [TICK_CNT_W-1:0] count;
  logic [TICK_CNT_W-1:0] mask0;
  logic                  adv;
  logic                  wrap0;
  logic                  wrap1;

  // Tick0 span is 256 steps shifted by the code.
  assign mask0 = TICK_CNT_W'((TICK0_BASE_SPAN << period_sel) - 16'h0001);
  assign adv   = run && step;
  assign wrap0 = adv && ((count & mask0) == mask0);
  assign wrap1 = adv && ((count & TICK1_MASK) == TICK1_MASK);

  // The count holds while stopped so a restart resumes the phase.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count       <= '0;
      tick0_pulse <= 1'b0;
      tick1_pulse <= 1'b0;
    end
    else
    begin
      if (adv)
        count <= count + TICK_CNT_W'(1);
      tick0_pulse <= wrap0;
      tick1_pulse <= wrap1;
    end
  end

endmodule

// ---- core_stack_model.sv ----
`timescale 1ns/10ps
// Stands in for the processor core: it counts calls, keeps the last vector
// and holds a return stack whose depth the bench chooses.
module core_stack_model #(
  parameter int DEPTH = 1
) (
  input  logic       mclk,
  input  logic       reset,
  input  logic       call_pulse,
  input  logic [7:0] call_vector,
  input  logic       ret,
  output logic       stack_full,
  output int         calls,
  output logic [7:0] last_vec
);
  int depth;

  // A shallow stack makes the full case cheap to reach.
  assign stack_full = (depth >= DEPTH);

  // Push on every call; a return that the bench asks for pops only if no call comes in the same cycle and the stack is not empty.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      depth    <= 0;
      calls    <= 0;
      last_vec <= 8'h00;
    end
    else if (call_pulse === 1'b1)
    begin
      depth    <= depth + 1;
      calls    <= calls + 1;
      last_vec <= call_vector;
    end
    else if (ret && depth > 0)
      depth <= depth - 1;
  end
endmodule

// ---- mcu_interrupt_vectoring_tb.sv ----
`timescale 1ns/10ps
module mcu_interrupt_vectoring_tb
  import irq_vec_pkg::*;
;
  logic       mclk;
  logic       reset;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [6:0] ev;
  logic       cmp_out;
  logic       tick_src;
  logic       stack_full;
  logic       call_pulse;
  logic [7:0] call_vector;
  logic       wake_up;
  logic       ret;
  int         calls;
  logic [7:0] last_vec;
  int         miscompares;
  int         tests_run;
  int         wakes;

  irq_vectoring u_irq_vectoring (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .counter0_overflow(ev[0]),
    .counter1_overflow(ev[1]), .serial_byte_done(ev[2]),
    .conv_done(ev[3]), .periph_edge(ev[4]), .eeprom_done(ev[5]),
    .low_volt_event(ev[6]), .cmp_out(cmp_out),
    .tick_source_clock(tick_src), .stack_full(stack_full),
    .call_pulse(call_pulse), .call_vector(call_vector),
    .wake_up(wake_up));

  core_stack_model #(.DEPTH(1)) u_core_stack_model (
    .mclk(mclk), .reset(reset), .call_pulse(call_pulse),
    .call_vector(call_vector), .ret(ret), .stack_full(stack_full),
    .calls(calls), .last_vec(last_vec));

  // System clock, and a slow free-running time base source.
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    tick_src = 1'b0;
    forever #20 tick_src = ~tick_src;
  end

  // Wake pulses are counted here since they stand for one cycle only.
  always @(posedge mclk)
    if (wake_up === 1'b1)
      wakes++;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data is looked at only in the one cycle where it stands.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic fire(input logic [6:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 7'h00;
  endtask

  // Enable first, then return: a full stack frees up and the waiting
  // request is taken at once, so exactly one call is expected and the
  // global enable reads back cleared.
  task automatic serve(input logic [7:0] c, input logic [6:0] m,
                       input logic [7:0] v, input logic [7:0] f);
    int n;
    n = calls;
    wr(3'h0, c);
    @(posedge mclk);
    ret <= 1'b1;
    @(posedge mclk);
    ret <= 1'b0;
    fire(m);
    repeat (3) @(posedge mclk);
    #1;
    chk(8'(calls - n), 8'h01);
    chk(last_vec, v);
    rd(3'h1, f);
    rd(3'h0, c & 8'hfe);
  endtask

  task automatic t_regs();
    chk(call_vector, 8'h0c);
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    wr(3'h4, 8'ha5);
    rd(3'h4, 8'ha5);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h1f);
    wr(3'h4, 8'h00);
  endtask

  task automatic t_core();
    int n;
    n = calls;
    wr(3'h0, 8'h01);
    fire(7'h02);
    repeat (4) @(posedge mclk);
    #1;
    chk(8'(calls - n), 8'h00);
    rd(3'h1, 8'h02);
    serve(8'h05, 7'h00, 8'h10, 8'h00);
    wr(3'h0, 8'h0e);
    fire(7'h07);
    rd(3'h1, 8'h07);
    serve(8'h0f, 7'h00, 8'h0c, 8'h06);
    serve(8'h0f, 7'h00, 8'h10, 8'h04);
    serve(8'h0f, 7'h00, 8'h14, 8'h00);
  endtask

  // The stack stays full after this call since nothing returns yet.
  task automatic t_stack();
    int n;
    serve(8'h03, 7'h01, 8'h0c, 8'h00);
    n = calls;
    wr(3'h0, 8'h09);
    fire(7'h04);
    repeat (5) @(posedge mclk);
    #1;
    chk(8'(calls - n), 8'h00);
    rd(3'h1, 8'h04);
    serve(8'h09, 7'h00, 8'h14, 8'h00);
  endtask

  task automatic t_shared();
    logic [7:0] mbit [4] = '{8'h01, 8'h10, 8'h20, 8'h40};
    wr(3'h2, 8'h7f);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h3, 8'h00);
      wr(3'h1, 8'h00);
      fire(7'(8'h08 << i));
      rd(3'h3, mbit[i]);
      rd(3'h1, 8'h08);
    end
    serve(8'h11, 7'h00, 8'h18, 8'h00);
    rd(3'h3, 8'h40);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h00);
    fire(7'h08);
    rd(3'h3, 8'h01);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h00);
  endtask

  task automatic t_wake_cmp();
    int w;
    w = wakes;
    fire(7'h02);
    repeat (3) @(posedge mclk);
    fire(7'h02);
    repeat (3) @(posedge mclk);
    #1;
    chk(8'(wakes - w), 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h08);
    cmp_out <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(3'h3, 8'h08);
    rd(3'h1, 8'h08);
    wr(3'h3, 8'h00);
    cmp_out <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(3'h3, 8'h08);
  endtask

  // Mclk/4 steps and code 000 give a tick near cycle 1024.
  task automatic t_tick();
    wr(3'h2, 8'h02);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'hc0);
    repeat (990) @(posedge mclk);
    rd(3'h3, 8'h00);
    repeat (60) @(posedge mclk);
    rd(3'h3, 8'h02);
    rd(3'h1, 8'h08);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h00);
    repeat (1100) @(posedge mclk);
    rd(3'h3, 8'h00);
  endtask

  // Main sequence: reset for 16 cycles, then each scenario in turn.
  initial
  begin
    reset     = 1'b1;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    ev        = 7'h00;
    cmp_out   = 1'b0;
    ret       = 1'b0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    t_regs();
    $display("done: registers");
    t_core();
    $display("done: core calls");
    t_stack();
    $display("done: stack full");
    t_shared();
    $display("done: shared");
    t_wake_cmp();
    $display("done: wake and comparator");
    t_tick();
    $display("done: tick");
    complete_run();
  end

  // The run needs about 2450 cycles; this cuts a hang well after that.
  initial
  begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule
